/* File: hdl/tbci_pkg.sv */
// Constants, types and helpers for the binary telecom command interpreter
package tbci_pkg;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_PROMPT = 8'h3C;
  localparam logic [7:0] CH_J = 8'h4A;
  localparam logic [7:0] CH_K = 8'h4B;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] PAR_COMMIT = 8'h00;
  localparam logic [7:0] PAR_CANCEL = 8'hFF;
  localparam logic [7:0] TERM_HI = 8'h7F;
  localparam logic [7:0] TERM_LO = 8'h00;
  localparam logic [15:0] SETUP_CODE = 16'h0C46;
  localparam logic [15:0] DEC_TEN = 16'h000A;
  localparam int LOC_MAX = 62;
  localparam logic [5:0] LOC_MAX_CNT = 6'h3E;
  localparam logic [15:0] FS_MAX_WORDS = 16'h0200;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int OPT_FS_BIT = 7;
  localparam int OPT_PORT_BIT = 6;
  localparam logic [1:0] PIDX_FLAGS = 2'h0;
  localparam logic [1:0] PIDX_OPT = 2'h1;
  localparam logic [1:0] PIDX_PORT = 2'h2;
  localparam logic [1:0] PIDX_W_OPT = 2'h1;
  localparam logic [1:0] PIDX_W_PORT = 2'h2;
  localparam logic [1:0] PIDX_W_LOC = 2'h3;
  localparam logic [1:0] BYTES_TIME = 2'h3;
  localparam logic [1:0] BYTES_LOC = 2'h3;
  localparam logic [1:0] BYTES_FS = 2'h1;
  // APB map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FS_PTR = 8'h08;
  localparam logic [7:0] ADDR_FS_AVAIL = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_PORTS_LSB = 8;
  localparam int ST_OPT_FS_BIT = 16;
  localparam int ST_OPT_PORT_BIT = 17;
  localparam int ST_SESSION_BIT = 18;
  localparam int ST_BUSY_BIT = 19;
  localparam int ST_CNT_LSB = 24;

  typedef enum logic [4:0] {
    S_CMD, S_J_CR, S_J_LF, S_J_PROMPT, S_PARAM, S_K_CR, S_K_LF, S_FLAGS, S_PORTS,
    S_LOC_SET, S_FS_SET, S_WAIT, S_GRAB, S_BYTES, S_TERM_HI, S_TERM_LO, S_SIG_HI, S_SIG_LO
  } tbci_state_t;

  typedef enum logic [1:0] {PH_TIME, PH_LOC, PH_FS} tbci_phase_t;

  function automatic logic [15:0] tbci_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : tbci_crc
endpackage : tbci_pkg

/* File: hdl/tbci_core.sv */
// Binary telecom command interpreter: setup, snapshot and dump over a byte link
// Operation
// - setup opens with REQUEST_SETUP_COMMAND CR, echoed, then LF and prompt.
// - first parameter byte bit n selects user flag n+1 for toggling.
// - a toggled flag inverts its present value.
// - option byte MSB appends final-storage data to later snapshots.
// - storage option cleared at session start, kept until changed or session end.
// - option byte bit 6 adds port toggle byte and port status; session scoped.
// - low six option bits are reserved and ignored.
// - with port option, next byte toggles ports; else bytes are locations.
// - locations accepted in any order, at most 62 stored.
// - zero byte commits setup, all-ones byte cancels it.
// - cancelled setup leaves flags and earlier location list untouched.
// - snapshot is K CR, both echoed, then LF before data.
// - snapshot carries time, flags, optional ports, locations, optional storage.
// - four time bytes, flags, four bytes per location, storage, 7F 00, signature.
// - count then F dumps that many storage locations, signature, no prompt.
// - signature depends on byte values and their order.
// - snapshot signature covers first time byte through the 7F 00 terminator.
// - storage data per snapshot limited to 1024 bytes.
// - time is minutes then tenths, 16 bits each, high byte first.
// - returned flags byte bit n reports user flag n+1.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module tbci_core
  import tbci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ring,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [15:0] time_minutes,
  input wire logic [15:0] time_tenths,
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] user_flags,
  output logic [7:0] loc_sel,
  input wire logic [31:0] loc_value,
  output logic [15:0] storage_read_pointer,
  input wire logic [15:0] fs_rdata
);
  typedef struct packed {
    tbci_state_t st;
    tbci_phase_t ph;
    logic dump;
    logic sig_on;
    logic [15:0] num;
    logic [15:0] crc;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rx_ready;
    logic [7:0] flags;
    logic [7:0] ports;
    logic opt_fs;
    logic opt_port;
    logic [1:0] pidx;
    logic [7:0] p_flags;
    logic [7:0] p_opt;
    logic [7:0] p_port;
    logic [LOC_MAX-1:0][7:0] p_list;
    logic [5:0] p_cnt;
    logic [LOC_MAX-1:0][7:0] list;
    logic [5:0] cnt;
    logic [5:0] idx;
    logic [1:0] bcnt;
    logic [31:0] word;
    logic [15:0] fs_left;
    logic [15:0] fs_ptr;
    logic [15:0] fs_avail;
    logic [7:0] loc_sel;
    logic enable;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tbci_regs_t;

  tbci_regs_t r;
  tbci_regs_t n;
  logic sess;
  logic tx_free;
  logic em;
  logic [7:0] eb;
  logic rx_take;
  logic apb_acc;
  logic apb_done;

  assign sess = r.enable & ring;
  assign tx_free = !r.tx_valid || tx_ready;
  assign rx_take = r.rx_ready && rx_valid;
  assign apb_acc = psel && penable && !r.pready;
  assign apb_done = psel && penable && r.pready;

  always_comb begin
    n = r;
    em = 1'b0;
    eb = 8'h00;
    if (r.tx_valid && tx_ready) begin
      n.tx_valid = 1'b0;
    end
    case (r.st)
      S_CMD: begin
        if (rx_take) begin
          if (rx_data >= CH_ZERO && rx_data <= CH_NINE) begin
            n.num = 16'(r.num * DEC_TEN + 16'(rx_data - CH_ZERO));
            em = 1'b1;
            eb = rx_data;
          end else if (rx_data == CH_J && r.num == SETUP_CODE) begin
            em = 1'b1;
            eb = rx_data;
            n.st = S_J_CR;
          end else if (rx_data == CH_K) begin
            em = 1'b1;
            eb = rx_data;
            n.st = S_K_CR;
          end else if (rx_data == CH_F) begin
            em = 1'b1;
            eb = rx_data;
            n.dump = 1'b1;
            n.fs_left = r.num;
            n.crc = CRC_INIT;
            n.sig_on = 1'b1;
            n.st = S_FS_SET;
            n.num = '0;
          end else begin
            n.num = '0;
          end
        end
      end
      S_J_CR, S_K_CR: begin
        if (rx_take) begin
          n.num = '0;
          if (rx_data == CH_CR) begin
            em = 1'b1;
            eb = rx_data;
            n.st = (r.st == S_J_CR) ? S_J_LF : S_K_LF;
          end else begin
            n.st = S_CMD;
          end
        end
      end
      S_J_LF, S_K_LF: begin
        if (tx_free) begin
          em = 1'b1;
          eb = CH_LF;
          n.pidx = '0;
          n.p_cnt = '0;
          n.st = (r.st == S_J_LF) ? S_J_PROMPT : S_BYTES;
          n.ph = PH_TIME;
          n.bcnt = BYTES_TIME;
          n.word = {time_minutes, time_tenths};
          n.crc = CRC_INIT;
          n.sig_on = (r.st == S_K_LF);
          n.dump = 1'b0;
        end
      end
      S_J_PROMPT: begin
        if (tx_free) begin
          em = 1'b1;
          eb = CH_PROMPT;
          n.st = S_PARAM;
        end
      end
      S_PARAM: begin
        if (rx_take) begin
          em = 1'b1;
          eb = rx_data;
          case (r.pidx)
            PIDX_FLAGS: begin
              n.p_flags = rx_data;
              n.pidx = PIDX_W_OPT;
            end
            PIDX_OPT: begin
              n.p_opt = rx_data;
              n.p_port = '0;
              n.pidx = rx_data[OPT_PORT_BIT] ? PIDX_W_PORT : PIDX_W_LOC;
            end
            PIDX_PORT: begin
              n.p_port = rx_data;
              n.pidx = PIDX_W_LOC;
            end
            default: begin
              if (rx_data == PAR_COMMIT) begin
                n.flags = r.flags ^ r.p_flags;
                n.ports = r.ports ^ r.p_port;
                n.opt_fs = r.p_opt[OPT_FS_BIT];
                n.opt_port = r.p_opt[OPT_PORT_BIT];
                n.list = r.p_list;
                n.cnt = r.p_cnt;
                n.st = S_CMD;
              end else if (rx_data == PAR_CANCEL) begin
                n.st = S_CMD;
              end else if (r.p_cnt < LOC_MAX_CNT) begin
                n.p_list[r.p_cnt] = rx_data;
                n.p_cnt = r.p_cnt + 6'h01;
              end
            end
          endcase
        end
      end
      S_FLAGS: begin
        if (tx_free) begin
          em = 1'b1;
          eb = r.flags;
          n.st = r.opt_port ? S_PORTS : S_LOC_SET;
          n.idx = '0;
        end
      end
      S_PORTS: begin
        if (tx_free) begin
          em = 1'b1;
          eb = port_in;
          n.st = S_LOC_SET;
        end
      end
      S_LOC_SET: begin
        if (r.idx < r.cnt) begin
          n.loc_sel = r.list[r.idx];
          n.ph = PH_LOC;
          n.bcnt = BYTES_LOC;
          n.st = S_WAIT;
        end else begin
          n.fs_left = !r.opt_fs ? '0 : (r.fs_avail > FS_MAX_WORDS) ? FS_MAX_WORDS
                                            : r.fs_avail;
          n.st = S_FS_SET;
        end
      end
      S_FS_SET: begin
        if (r.fs_left != '0) begin
          n.ph = PH_FS;
          n.bcnt = BYTES_FS;
          n.st = S_WAIT;
        end else begin
          n.st = r.dump ? S_SIG_HI : S_TERM_HI;
        end
      end
      S_WAIT: n.st = S_GRAB;
      S_GRAB: begin
        n.word = (r.ph == PH_FS) ? {fs_rdata, 16'h0000} : loc_value;
        n.st = S_BYTES;
      end
      S_BYTES: begin
        if (tx_free) begin
          em = 1'b1;
          eb = r.word[31:24];
          n.word = r.word << 8;
          n.bcnt = r.bcnt - 2'h1;
          if (r.bcnt == '0) begin
            case (r.ph)
              PH_TIME: n.st = S_FLAGS;
              PH_LOC: begin
                n.idx = r.idx + 6'h01;
                n.st = S_LOC_SET;
              end
              default: begin
                n.fs_left = r.fs_left - 16'h0001;
                n.fs_ptr = r.fs_ptr + 16'h0001;
                if (!r.dump) begin
                  n.fs_avail = r.fs_avail - 16'h0001;
                end
                n.st = S_FS_SET;
              end
            endcase
          end
        end
      end
      S_TERM_HI: begin
        if (tx_free) begin
          em = 1'b1;
          eb = TERM_HI;
          n.st = S_TERM_LO;
        end
      end
      S_TERM_LO: begin
        if (tx_free) begin
          em = 1'b1;
          eb = TERM_LO;
          n.st = S_SIG_HI;
        end
      end
      S_SIG_HI: begin
        if (tx_free) begin
          em = 1'b1;
          eb = r.crc[15:8];
          n.sig_on = 1'b0;
          n.st = S_SIG_LO;
        end
      end
      S_SIG_LO: begin
        if (tx_free) begin
          em = 1'b1;
          eb = r.crc[7:0];
          n.dump = 1'b0;
          n.st = S_CMD;
        end
      end
      default: n.st = S_CMD;
    endcase
    if (em) begin
      n.tx_valid = 1'b1;
      n.tx_data = eb;
      // Registered flag keeps the LF and the F echo out of the sum
      if (r.sig_on && r.st != S_SIG_HI && r.st != S_SIG_LO) begin
        n.crc = tbci_crc(n.crc, eb);
      end
    end
    // Session end drops the interpreter back to command wait and clears both options; flags, ports and locations are kept
    if (!sess) begin
      n.st = S_CMD;
      n.num = '0;
      n.opt_fs = 1'b0;
      n.opt_port = 1'b0;
      n.sig_on = 1'b0;
      n.dump = 1'b0;
    end
    // Receive only with the transmit slot empty, so every echo has room
    n.rx_ready = sess && !n.tx_valid && !rx_take && (n.st == S_CMD || n.st == S_J_CR ||
                                        n.st == S_K_CR || n.st == S_PARAM);
    // APB: one wait state, answer registered
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (apb_acc) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr)
        ADDR_CTRL: n.prdata[CTRL_EN_BIT] = r.enable;
        ADDR_STATUS: begin
          n.prdata[7:0] = r.flags;
          n.prdata[ST_PORTS_LSB +: 8] = r.ports;
          n.prdata[ST_OPT_FS_BIT] = r.opt_fs;
          n.prdata[ST_OPT_PORT_BIT] = r.opt_port;
          n.prdata[ST_SESSION_BIT] = sess;
          n.prdata[ST_BUSY_BIT] = (r.st != S_CMD);
          n.prdata[ST_CNT_LSB +: 6] = r.cnt;
        end
        ADDR_FS_PTR: n.prdata[15:0] = r.fs_ptr;
        ADDR_FS_AVAIL: n.prdata[15:0] = r.fs_avail;
        default: n.pslverr = 1'b1;
      endcase
    end
    // Writes land where the master sees pready; placed last so software wins
    if (apb_done && pwrite) begin
      case (paddr)
        ADDR_CTRL: n.enable = pwdata[CTRL_EN_BIT];
        ADDR_FS_PTR: n.fs_ptr = pwdata[15:0];
        ADDR_FS_AVAIL: n.fs_avail = pwdata[15:0];
        default: n.enable = r.enable;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign rx_ready = r.rx_ready;
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign port_out = r.ports;
  assign user_flags = r.flags;
  assign loc_sel = r.loc_sel;
  assign storage_read_pointer = r.fs_ptr;
endmodule : tbci_core

/* File: dv/tbci_asserts.sv */
// Port-level assertions for the command interpreter
`timescale 1ns/1ps
module tbci_asserts
  import tbci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ring,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  chk_apb_wait: assert property (ce && psel && penable && !pready |=> pready)
    else $error("no answer after wait state");
  chk_apb_one_wait: assert property ($rose(penable) |-> !pready)
    else $error("answer without wait state");
  chk_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_ready_cause: assert property (pready |-> $past(penable))
    else $error("pready without access");
  chk_rx_take_drop: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("rx_ready kept after take");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  chk_ring_gate: assert property (!ring |=> !rx_ready)
    else $error("take without ring");
  chk_echo_snap: assert property (rx_valid && rx_ready && rx_data == CH_K
    |=> tx_valid && tx_data == CH_K)
    else $error("snapshot letter not echoed");
  chk_rx_slot: assert property (rx_ready |-> !tx_valid)
    else $error("take offered with tx busy");
endmodule : tbci_asserts

bind tbci_core tbci_asserts u_chk (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
  .ring, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);

/* File: dv/tbci_host.sv */
// Far-end terminal model: one byte at a time, echo sink with stalls
`timescale 1ns/1ps
module tbci_host (
  input wire logic pclk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end
  // Slow mode stalls the sink on random cycles
  always @(posedge pclk) tx_ready <= slow ? ($urandom_range(2) == 0) : 1'b1;
  initial tx_ready = 1'b1;
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    // Released line must not keep the last byte
    rx_data <= ~b;
  endtask : send
endmodule : tbci_host

/* File: dv/tb.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module tb
  import tbci_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, ring;
  logic rx_valid, rx_ready, tx_valid, tx_ready, opt_fs, opt_port, er;
  logic [7:0] paddr, rx_data, tx_data, port_in, port_out, user_flags, loc_sel, ex, a, p;
  logic [7:0] expq[$], locs[$], dq[$], flags, ports;
  logic [31:0] pwdata, prdata, loc_value, rd;
  logic [15:0] time_minutes, time_tenths, storage_read_pointer, fs_rdata, c16;
  int bad_count, comparisons;

  tbci_core dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ring, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .time_minutes, .time_tenths, .port_in, .port_out, .user_flags, .loc_sel, .loc_value,
    .storage_read_pointer, .fs_rdata);
  tbci_host host (.pclk, .rx_ready, .rx_valid, .rx_data, .tx_ready);

  function automatic logic [31:0] lv(input logic [7:0] l);
    return {l, ~l, l ^ 8'h5A, 8'hC3};
  endfunction : lv
  function automatic logic [15:0] fw(input logic [15:0] q);
    return q ^ 16'h1234;
  endfunction : fw
  // Stand-ins for input storage and final storage
  assign loc_value = lv(loc_sel);
  assign fs_rdata = fw(storage_read_pointer);

  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("unexpected tx byte: expected none seen %h", tx_data);
      end else begin
        ex = expq.pop_front();
        `CHK("tx byte", ex, tx_data)
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_st(input logic [31:0] e);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", e, rd & 32'h3F0700FF)
  endtask : chk_st

  task automatic drain(input string n);
    int k;
    k = 0;
    while (expq.size() != 0 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    repeat (3) @(posedge pclk);
    `CHK("leftover", 0, expq.size())
    $display("test %s done", n);
  endtask : drain

  task automatic run(input logic [7:0] s[$], input logic [7:0] e[$]);
    expq = {expq, e};
    foreach (s[i]) host.send(s[i]);
  endtask : run

  task automatic setup(input logic [7:0] fa, fb, fp, input logic [7:0] ln[$],
    input logic [7:0] t);
    logic [7:0] s[$], tl[$];
    s = {8'h33, 8'h31, 8'h34, 8'h32, CH_J, CH_CR};
    tl = {fa, fb};
    if (fb[OPT_PORT_BIT]) tl.push_back(fp);
    tl = {tl, ln, t};
    run({s, tl}, {s, CH_LF, CH_PROMPT, tl});
    if (t == PAR_COMMIT) begin
      flags = flags ^ fa;
      if (fb[OPT_PORT_BIT]) ports = ports ^ fp;
      opt_fs = fb[OPT_FS_BIT];
      opt_port = fb[OPT_PORT_BIT];
      locs = ln;
    end
  endtask : setup

  task automatic snap(input int nfs, input logic [15:0] fp);
    logic [7:0] r[$];
    logic [31:0] v;
    logic [15:0] c;
    r = {time_minutes[15:8], time_minutes[7:0], time_tenths[15:8], time_tenths[7:0], flags};
    if (opt_port) r.push_back(port_in);
    foreach (locs[i]) begin
      v = lv(locs[i]);
      r = {r, v[31:24], v[23:16], v[15:8], v[7:0]};
    end
    for (int i = 0; i < nfs; i++) begin
      c = fw(fp + 16'(i));
      r = {r, c[15:8], c[7:0]};
    end
    r = {r, TERM_HI, TERM_LO};
    c = crc(r);
    run({CH_K, CH_CR}, {CH_K, CH_CR, CH_LF, r, c[15:8], c[7:0]});
  endtask : snap

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    repeat (50000) @(posedge pclk);
    bad_count++;
    $display("unexpected run length: expected end seen hang");
    test_done;
  end

  initial begin
    void'($urandom(92));
    {psel, penable, pwrite, ring, ce, presetn} = 6'h02;
    paddr = 8'h00;
    pwdata = 32'h0;
    time_minutes = 16'($urandom);
    time_tenths = 16'($urandom);
    port_in = 8'($urandom);
    {flags, ports, opt_fs, opt_port} = 18'h0;
    repeat (3) @(posedge pclk);
    `CHK("reset outputs", 18'h0, {tx_valid, rx_ready, user_flags, port_out})
    presetn <= 1'b1;
    chk_st(32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, ADDR_CTRL, 32'h1);
    ring <= 1'b1;
    drain("reset");
    a = 8'($urandom);
    p = 8'($urandom);
    host.slow = 1'b1;
    setup(a, 8'hC5, p, {8'h03, 8'h01, 8'h02}, PAR_COMMIT);
    drain("setup");
    `CHK("flags", flags, user_flags)
    `CHK("ports", ports, port_out)
    chk_st(32'h03070000 | {24'h0, flags});
    apb(1'b1, ADDR_FS_PTR, 32'h10);
    apb(1'b1, ADDR_FS_AVAIL, 32'h2);
    snap(2, 16'h0010);
    drain("snapshot");
    apb(1'b0, ADDR_FS_AVAIL, 32'h0);
    `CHK("fs avail", 32'h0, rd)
    `CHK("fs pointer", 16'h0012, storage_read_pointer)
    host.send(8'h5A);
    host.slow = 1'b0;
    setup(8'hFF, 8'h00, 8'h00, {8'h05}, PAR_CANCEL);
    snap(0, 16'h0);
    drain("cancel");
    `CHK("flags kept", flags, user_flags)
    apb(1'b1, ADDR_FS_AVAIL, 32'h201);
    snap(512, 16'h0012);
    drain("storage limit");
    apb(1'b0, ADDR_FS_AVAIL, 32'h0);
    `CHK("fs limit", 32'h1, rd)
    apb(1'b1, ADDR_FS_PTR, 32'h40);
    rd = {fw(16'h0040), fw(16'h0041)};
    dq = {rd[31:24], rd[23:16], rd[15:8], rd[7:0]};
    c16 = crc(dq);
    run({8'h32, CH_F}, {8'h32, CH_F, dq, c16[15:8], c16[7:0]});
    drain("dump");
    ring <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_st(32'h03000000 | {24'h0, flags});
    $display("test session done");
    test_done;
  end
endmodule : tb
